// ---- shared/ocp_defines.vh ----
// Constants for the output overcurrent protection block
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_MODE        8'h04
`define REG_ONDEMAND    8'h08
`define REG_QSTATUS     8'h0C
`define REG_CHSTATUS    8'h10
`define REG_WINDOW      8'h14

// Mode register fields
`define MODE_FAIL_BIT   0
`define MODE_PWM_BIT    1
`define MODE_PROF_LO    2
`define MODE_PROF_HI    3
`define MODE_WAKE_BIT   4

// Ballast profile encodings
`define PROF_ALL        2'h0
`define PROF_CH3        2'h1
`define PROF_CH34       2'h2
`define PROF_NONE       2'h3

// Window phases
`define PH_IDLE         3'h0
`define PH_LVL1         3'h1
`define PH_LVL2         3'h2
`define PH_LVL3         3'h3
`define PH_STEADY       3'h4

// Timing
`define CLK_HZ          20000000
`define DEGLITCH_NS     2000
`define DEGLITCH_CYC    ((`DEGLITCH_NS * 20 + 999) / 1000)
`define LVL1_US         200
`define LVL2_US         8000
`define LVL3_US         16000
`define SSC_US          10
`define RESTART_US      10000
`define SLOW_DIV        8
`define RESP_SLVERR     2'h2
`define RESP_OKAY       2'h0

`endif

// ---- hw/ocp_top.v ----
// Output overcurrent protection: fault shutdown, restart and inrush windows
// Notes on behaviour
// - Any channel fault turns that output off once the deglitch time elapses.
// - Fault shutdowns use the fast turn-off path, no edge shaping, high slew.
// - Fast turn-off is latched so it survives battery undervoltage.
// - Normal mode faults set quick status and the channel status bit.
// - Fault is OR of undervoltage, pump failure, three inrush levels, steady limit, heat, short, open load.
// - Fail mode: level two, three, steady limit, undervoltage recover automatically.
// - Fail mode: heat, short or level one latch off until wake or mode change.
// - In PWM mode window timers advance only while the drive command is high.
// - Window counting freezes during undervoltage, pump failure or heat shutdown.
// - Severe short detect is armed only briefly after each off-to-on transition.
// - Normal mode drive off then on clears the window counter, full sequence.
// - Rewriting drive on without an off continues the window count.
// - Without enabled input pins, on bits govern the inrush windows.
// - Fail mode: input pin toggle starts windows, and the input pin, not the on bit, turns output on.
// - At full duty the level two timer runs divided by 8 while open load is high.
// - Ballast extension stretches level two window up to 64 ms from 8 ms.
// - Ballast extension engages at each sequence start, except in on-demand mode.
// - Profile select 00 all, 01 channel 3, 10 channels 3 and 4, 11 none.
// - On-demand off: steady limit after windows; on: steady event reruns two, three.
// - An inrush level or steady limit shutdown clears that channel's on-demand bit; a severe short does not.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`include "ocp_defines.vh"

module ocp_top #(
	parameter NCH          = 5,
	parameter LVL1_CYC     = `LVL1_US * 20,
	parameter LVL2_CYC     = `LVL2_US * 20,
	parameter LVL3_CYC     = `LVL3_US * 20,
	parameter SSC_CYC      = `SSC_US * 20,
	parameter RESTART_CYC  = `RESTART_US * 20,
	parameter CW           = 20
)(
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              undervoltage_flag,
	input  wire              charge_pump_failure,
	input  wire [NCH-1:0]    off_state_open_load,
	input  wire [NCH-1:0]    channel_over_temperature,
	input  wire [NCH-1:0]    inrush_level_one,
	input  wire [NCH-1:0]    inrush_level_two,
	input  wire [NCH-1:0]    inrush_level_three,
	input  wire [NCH-1:0]    steady_overcurrent_limit,
	input  wire [NCH-1:0]    severe_short_detect,
	input  wire [NCH-1:0]    input_pin_toggle,
	input  wire [NCH-1:0]    pwm_in,
	input  wire              pwm_clock_lost,
	output reg  [NCH-1:0]    channel_drive_command,
	output reg  [NCH-1:0]    fast_turn_off,
	output reg  [NCH-1:0]    ssc_armed,
	output reg  [NCH*3-1:0]  window_phase
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	localparam SW = 3 + 9 * NCH;
	wire [SW-1:0] raw_in = {undervoltage_flag, charge_pump_failure, pwm_clock_lost,
		off_state_open_load, channel_over_temperature, inrush_level_one,
		inrush_level_two, inrush_level_three, steady_overcurrent_limit,
		severe_short_detect, input_pin_toggle, pwm_in};
	reg  [SW-1:0] meta_q;
	reg  [SW-1:0] sync_q;

	// Two flops before any logic reads the pins
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= {SW{1'b0}};
			sync_q <= {SW{1'b0}};
		end
		else
		begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	wire           uv_s   = sync_q[SW-1];
	wire           cpf_s  = sync_q[SW-2];
	wire           pcl_s  = sync_q[SW-3];
	wire [NCH-1:0] ol_s   = sync_q[8*NCH +: NCH];
	wire [NCH-1:0] ot_s   = sync_q[7*NCH +: NCH];
	wire [NCH-1:0] l1_s   = sync_q[6*NCH +: NCH];
	wire [NCH-1:0] l2_s   = sync_q[5*NCH +: NCH];
	wire [NCH-1:0] l3_s   = sync_q[4*NCH +: NCH];
	wire [NCH-1:0] lo_s   = sync_q[3*NCH +: NCH];
	wire [NCH-1:0] ssc_s  = sync_q[2*NCH +: NCH];
	wire [NCH-1:0] pin_s  = sync_q[NCH +: NCH];
	wire [NCH-1:0] pwm_s  = sync_q[0 +: NCH];

	// ************************************************************
	// Register file and AXI4-Lite slave
	// ************************************************************
	reg  [NCH-1:0] channel_on_bit_q;
	reg  [NCH-1:0] on_demand_inrush_bit_q;
	reg  [NCH-1:0] chan_status_q;
	reg  [NCH-1:0] latched_off_q;
	reg            quick_status_q;
	reg            fail_mode_q;
	reg            pwm_mode_q;
	reg            ballast_profile_select_hi_q;
	reg            ballast_profile_select_lo_q;
	reg  [7:0]     awaddr_q;
	reg  [31:0]    wdata_q;
	reg            aw_have_q;
	reg            w_have_q;
	wire [NCH-1:0] od_clear;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire           wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
	wire           wr_ctrl = wr_go && (awaddr_q == `REG_CTRL);
	wire           wr_mode = wr_go && (awaddr_q == `REG_MODE);
	wire           wr_od   = wr_go && (awaddr_q == `REG_ONDEMAND);
	wire           wr_qst  = wr_go && (awaddr_q == `REG_QSTATUS);
	wire           wr_cst  = wr_go && (awaddr_q == `REG_CHSTATUS);
	wire           wr_ok   = wr_ctrl | wr_mode | wr_od | wr_qst | wr_cst;
	wire [NCH-1:0] on_wr1  = wr_ctrl ? wdata_q[NCH-1:0] : {NCH{1'b0}};
	wire           mode_chg = wr_mode && (wdata_q[`MODE_FAIL_BIT] != fail_mode_q);
	wire           wake     = wr_mode && wdata_q[`MODE_WAKE_BIT];

	// Write channel capture and response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (wr_go)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read data mux
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`REG_CTRL:     s_axi_rdata <= {{(32-NCH){1'b0}}, channel_on_bit_q};
				`REG_MODE:     s_axi_rdata <= {28'h0000000, ballast_profile_select_hi_q,
					ballast_profile_select_lo_q, pwm_mode_q, fail_mode_q};
				`REG_ONDEMAND: s_axi_rdata <= {{(32-NCH){1'b0}}, on_demand_inrush_bit_q};
				`REG_QSTATUS:  s_axi_rdata <= {31'h00000000, quick_status_q};
				`REG_CHSTATUS: s_axi_rdata <= {{(32-NCH){1'b0}}, chan_status_q};
				`REG_WINDOW:   s_axi_rdata <= {{(32-3*NCH){1'b0}}, window_phase};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Software controls; on-demand clear by hardware wins over a write
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			channel_on_bit_q            <= {NCH{1'b0}};
			on_demand_inrush_bit_q      <= {NCH{1'b0}};
			fail_mode_q                 <= 1'b0;
			pwm_mode_q                  <= 1'b0;
			ballast_profile_select_hi_q <= 1'b0;
			ballast_profile_select_lo_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				channel_on_bit_q <= wdata_q[NCH-1:0];
			if (wr_mode)
			begin
				fail_mode_q                 <= wdata_q[`MODE_FAIL_BIT];
				pwm_mode_q                  <= wdata_q[`MODE_PWM_BIT];
				ballast_profile_select_hi_q <= wdata_q[`MODE_PROF_HI];
				ballast_profile_select_lo_q <= wdata_q[`MODE_PROF_LO];
			end
			on_demand_inrush_bit_q <= (wr_od ? wdata_q[NCH-1:0] : on_demand_inrush_bit_q)
				& ~od_clear;
		end
	end

	// ************************************************************
	// Per-channel protection
	// ************************************************************
	// Ballast extension allowed for a channel index (0 based)
	function ext_allowed;
		input [1:0]  prof;
		input integer ch;
		begin
			case (prof)
				`PROF_ALL:  ext_allowed = 1'b1;
				`PROF_CH3:  ext_allowed = (ch == 2);
				`PROF_CH34: ext_allowed = (ch == 2) || (ch == 3);
				default:    ext_allowed = 1'b0;
			endcase
		end
	endfunction

	wire [1:0]     prof = fail_mode_q ? `PROF_ALL
		: {ballast_profile_select_hi_q, ballast_profile_select_lo_q};
	wire           freeze = uv_s | cpf_s;
	wire [NCH-1:0] fault_raw;
	wire [NCH-1:0] oc_any = l1_s | l2_s | l3_s | lo_s;
	reg  [NCH-1:0] fault_hit;
	reg  [NCH-1:0] od_clear_r;
	assign od_clear = od_clear_r;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : chan
			reg  [7:0]    dg_q;
			reg  [CW-1:0] win_q;
			reg  [CW-1:0] rst_q;
			reg  [2:0]    div_q;
			reg  [2:0]    ph_q;
			reg           drv_prev_q;
			reg           pin_prev_q;
			reg           ext_q;
			reg           auto_q;
			reg           ssc_q;
			reg  [CW-1:0] ssc_cnt_q;

			// Fault OR, short only counts while armed
			assign fault_raw[g] = uv_s | l1_s[g] | l2_s[g] | l3_s[g] | lo_s[g] | ot_s[g]
				| (ssc_s[g] & ssc_q) | cpf_s | ol_s[g];

			wire want    = fail_mode_q ? pin_s[g] : channel_on_bit_q[g];
			wire drive   = want & ~fast_turn_off[g] & ~latched_off_q[g] & ~auto_q;
			wire restart = fail_mode_q ? (pin_s[g] & ~pin_prev_q)
				: (drive & ~drv_prev_q);
			wire tick_en = (!pwm_mode_q || pwm_s[g]) && drive && !freeze && !ot_s[g];
			wire full    = fail_mode_q ? pin_s[g] : (pcl_s || !pwm_mode_q);
			wire slow    = ext_q && full && ol_s[g];
			wire tick2   = slow ? (div_q == 3'h7) : 1'b1;
			wire hard    = ot_s[g] | (ssc_s[g] & ssc_q) | l1_s[g];
			wire trip    = fault_raw[g] && (dg_q == `DEGLITCH_CYC - 1); // Deglitch ends now

			// Deglitch, then latched fast turn-off
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					dg_q                <= 8'h00;
					fast_turn_off[g]    <= 1'b0;
					fault_hit[g]        <= 1'b0;
				end
				else
				begin
					fault_hit[g] <= 1'b0;
					if (!fault_raw[g])
						dg_q <= 8'h00;
					else if (dg_q < `DEGLITCH_CYC)
						dg_q <= dg_q + 8'h01;
					if (trip)
					begin
						fast_turn_off[g] <= 1'b1;
						fault_hit[g]     <= 1'b1;
					end
					else if (on_wr1[g] || wake || mode_chg
						|| (fail_mode_q && auto_q && rst_q == 1))
						fast_turn_off[g] <= 1'b0;
				end
			end

			// Fail mode latch off and automatic restart
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					latched_off_q[g] <= 1'b0;
					auto_q           <= 1'b0;
					rst_q            <= {CW{1'b0}};
				end
				else if (wake || mode_chg)
				begin
					latched_off_q[g] <= 1'b0;
					auto_q           <= 1'b0;
				end
				else if (fault_hit[g] && fail_mode_q)
				begin
					if (hard)
						latched_off_q[g] <= 1'b1;
					else
					begin
						auto_q <= 1'b1;
						rst_q  <= RESTART_CYC[CW-1:0];
					end
				end
				else if (auto_q)
				begin
					rst_q <= rst_q - {{(CW-1){1'b0}}, 1'b1};
					if (rst_q == 1)
						auto_q <= 1'b0;
				end
			end

			// Status flags: set wins over software clear
			always @(posedge aclk)
			begin
				if (!aresetn)
					chan_status_q[g] <= 1'b0;
				else if (fault_hit[g] && !fail_mode_q)
					chan_status_q[g] <= 1'b1;
				else if (wr_cst && wdata_q[g])
					chan_status_q[g] <= 1'b0;
			end

			// Inrush window sequencer
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					ph_q       <= `PH_IDLE;
					win_q      <= {CW{1'b0}};
					div_q      <= 3'h0;
					ext_q      <= 1'b0;
					drv_prev_q <= 1'b0;
					pin_prev_q <= 1'b0;
					od_clear_r[g] <= 1'b0;
				end
				else
				begin
					drv_prev_q    <= drive;
					pin_prev_q    <= pin_s[g];
					od_clear_r[g] <= fault_hit[g] & oc_any[g];
					if (restart)
					begin
						ph_q  <= `PH_LVL1;
						win_q <= {CW{1'b0}};
						div_q <= 3'h0;
						ext_q <= ext_allowed(prof, g) & ~on_demand_inrush_bit_q[g];
					end
					else if (on_demand_inrush_bit_q[g] && ph_q == `PH_STEADY && lo_s[g])
					begin
						ph_q  <= `PH_LVL2;
						win_q <= {CW{1'b0}};
					end
					else if (tick_en && ph_q != `PH_IDLE && ph_q != `PH_STEADY)
					begin
						div_q <= div_q + 3'h1;
						if (ph_q != `PH_LVL2 || tick2)
							win_q <= win_q + {{(CW-1){1'b0}}, 1'b1};
						case (ph_q)
							`PH_LVL1: if (win_q == LVL1_CYC - 1)
								begin
									ph_q  <= `PH_LVL2;
									win_q <= {CW{1'b0}};
								end
							`PH_LVL2: if (win_q == LVL2_CYC - 1 && (ph_q != `PH_LVL2 || tick2))
								begin
									ph_q  <= `PH_LVL3;
									win_q <= {CW{1'b0}};
								end
							`PH_LVL3: if (win_q == LVL3_CYC - 1)
									ph_q <= `PH_STEADY;
							default: ph_q <= ph_q;
						endcase
					end
				end
			end

			// Severe short arming window after turn-on
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					ssc_q     <= 1'b0;
					ssc_cnt_q <= {CW{1'b0}};
				end
				else if (drive && !drv_prev_q)
				begin
					ssc_q     <= 1'b1;
					ssc_cnt_q <= SSC_CYC[CW-1:0];
				end
				else if (ssc_q)
				begin
					ssc_cnt_q <= ssc_cnt_q - {{(CW-1){1'b0}}, 1'b1};
					if (ssc_cnt_q == 1 || !drive)
						ssc_q <= 1'b0;
				end
			end

			// Registered outputs
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					channel_drive_command[g] <= 1'b0;
					ssc_armed[g]             <= 1'b0;
					window_phase[3*g +: 3]   <= `PH_IDLE;
				end
				else
				begin
					channel_drive_command[g] <= drive & ~trip & (!pwm_mode_q | pwm_s[g]);
					ssc_armed[g]             <= ssc_q;
					window_phase[3*g +: 3]   <= ph_q;
				end
			end
		end
	endgenerate

	// Quick status: any channel fault in normal mode
	always @(posedge aclk)
	begin
		if (!aresetn)
			quick_status_q <= 1'b0;
		else if (|fault_hit && !fail_mode_q)
			quick_status_q <= 1'b1;
		else if (wr_qst && wdata_q[0])
			quick_status_q <= 1'b0;
	end

endmodule // ocp_top

// ---- sim/ocp_checker_properties.sv ----
// Port-level checks for the overcurrent protection block
module ocp_checker #(
	parameter NCH     = 5,
	parameter SSC_CYC = 4
)(
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic             undervoltage_flag,
	input wire logic [NCH-1:0]   channel_over_temperature,
	input wire logic [NCH-1:0]   inrush_level_one,
	input wire logic [NCH-1:0]   inrush_level_two,
	input wire logic [NCH-1:0]   inrush_level_three,
	input wire logic [NCH-1:0]   steady_overcurrent_limit,
	input wire logic [NCH-1:0]   severe_short_detect,
	input wire logic [NCH-1:0]   channel_drive_command,
	input wire logic [NCH-1:0]   fast_turn_off,
	input wire logic [NCH-1:0]   ssc_armed,
	input wire logic [NCH*3-1:0] window_phase
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] run_q;
	logic [7:0] ssc_q;
	wire        trip_any = undervoltage_flag | (|{channel_over_temperature, inrush_level_one,
		inrush_level_two, inrush_level_three, steady_overcurrent_limit, severe_short_detect});
	// Length of the current unbroken trip run and of the armed short window
	always @(posedge aclk)
	begin
		run_q <= (!aresetn || !trip_any) ? 8'h00 : run_q + {7'h00, run_q != 8'hFF};
		ssc_q <= (!aresetn || !(|ssc_armed)) ? 8'h00 : ssc_q + {7'h00, ssc_q != 8'hFF};
	end
	a_fto_blocks_drive: assert property ((fast_turn_off & channel_drive_command) == '0)
		else $error("Output driven while forced off");
	a_deglitch_min: assert property ($rose(|fast_turn_off) |-> run_q >= 8'd40)
		else $error("Shutdown before the deglitch time");
	a_fto_uv_hold: assert property (fast_turn_off[0] && undervoltage_flag && !s_axi_wvalid
		&& !$past(s_axi_wvalid) |=> fast_turn_off[0]) else $error("Shutdown lost in undervoltage");
	a_ssc_brief: assert property (ssc_q <= SSC_CYC + 2)
		else $error("Short detection armed too long");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("Read data dropped early");
	a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("Read address ready wrong");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read not answered");
	for (genvar k = 0; k < NCH; k++)
	begin : g_ph
		a_phase_legal: assert property (window_phase[k*3+:3] <= 3'h4)
			else $error("Window phase out of range");
	end
	c_shutdown: cover property ($rose(|fast_turn_off));
	c_restart: cover property ($fell(|fast_turn_off));
	c_ssc: cover property ($rose(|ssc_armed));
endmodule // ocp_checker

bind ocp_top ocp_checker #(.NCH(NCH), .SSC_CYC(SSC_CYC)) ocp_checker_inst (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .undervoltage_flag,
	.channel_over_temperature, .inrush_level_one, .inrush_level_two, .inrush_level_three,
	.steady_overcurrent_limit, .severe_short_detect, .channel_drive_command, .fast_turn_off,
	.ssc_armed, .window_phase);

// ---- sim/lamp_load_model.sv ----
// Behavioural lamp load raising trip lines on request
module lamp_load_model (
	input  wire logic [4:0] drive,
	input  wire logic [2:0] kind,
	input  wire logic [4:0] req,
	output logic      [4:0] steady,
	output logic      [4:0] lvl1,
	output logic      [4:0] lvl2,
	output logic      [4:0] lvl3,
	output logic      [4:0] shorted,
	output logic      [4:0] heat,
	output logic      [4:0] open_load
);
	timeunit 1ns;
	timeprecision 1ns;
	// Current trips need current, so they vanish once the channel stops driving
	wire [4:0] hot = req & drive;
	assign steady = (kind == 3'h0) ? hot : 5'h00;
	assign lvl1 = (kind == 3'h1) ? hot : 5'h00;
	assign lvl2 = (kind == 3'h2) ? hot : 5'h00;
	assign lvl3 = (kind == 3'h3) ? hot : 5'h00;
	assign shorted = (kind == 3'h4) ? hot : 5'h00;
	// Heat outlasts the drive; open load shows only on an idle output
	assign heat = (kind == 3'h5) ? req : 5'h00;
	assign open_load = (kind == 3'h6) ? req & ~drive : 5'h00;
endmodule // lamp_load_model

// ---- sim/output_overcurrent_protection_tb.sv ----
// Self-checking bench for the overcurrent protection block
`include "ocp_defines.vh"
module output_overcurrent_protection_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] a; logic [31:0] d, q; logic [1:0] br, rr;} row_t;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, undervoltage_flag, charge_pump_failure, pwm_clock_lost;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [4:0]  input_pin_toggle, req, pwm_in;
	logic [2:0]  kind;
	logic [1:0]  rsp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [4:0]  off_state_open_load, channel_over_temperature, inrush_level_one, inrush_level_two;
	wire  [4:0]  inrush_level_three, steady_overcurrent_limit, severe_short_detect;
	wire  [4:0]  channel_drive_command, fast_turn_off, ssc_armed;
	wire  [14:0] window_phase;
	int          n_fail, tests_run, n;
	row_t        rows [7] = '{'{`REG_CTRL, 0, 0, `RESP_OKAY, `RESP_OKAY},
		'{`REG_MODE, 32'h4, 32'h4, `RESP_OKAY, `RESP_OKAY}, '{`REG_MODE, 32'h8, 32'h8, 0, 0},
		'{`REG_MODE, 32'hC, 32'hC, 0, 0}, '{`REG_MODE, 0, 0, 0, 0},
		'{`REG_ONDEMAND, 32'h1F, 32'h1F, 0, 0}, '{8'h18, 32'h1, 0, `RESP_SLVERR, `RESP_SLVERR}};

	ocp_top #(.LVL1_CYC(8), .LVL2_CYC(16), .LVL3_CYC(16), .SSC_CYC(4), .RESTART_CYC(32))
	ocp_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .undervoltage_flag, .charge_pump_failure, .off_state_open_load,
		.channel_over_temperature, .inrush_level_one, .inrush_level_two, .inrush_level_three,
		.steady_overcurrent_limit, .severe_short_detect, .input_pin_toggle, .pwm_in,
		.pwm_clock_lost, .channel_drive_command, .fast_turn_off, .ssc_armed, .window_phase);
	lamp_load_model lamp_load_model_inst (.drive(channel_drive_command), .kind, .req,
		.steady(steady_overcurrent_limit), .lvl1(inrush_level_one), .lvl2(inrush_level_two),
		.lvl3(inrush_level_three), .shorted(severe_short_detect), .heat(channel_over_temperature),
		.open_load(off_state_open_load));

	// Clock at 20 MHz
	initial
	begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bounded wait guard: running out counts as a mismatch
	task automatic tick(inout int c);
		c++;
		if (c > 400)
		begin
			n_fail++;
			report_and_stop();
		end
	endtask

	// One AXI4-Lite write or read, entered just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int c;
		logic ta, tw, tr, td;
		c = 0;
		td = 0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (!td)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tr = s_axi_arvalid & s_axi_arready;
			td = wr ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
			rsp = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tr)
				s_axi_arvalid <= 1'b0;
			if (td)
				{s_axi_bready, s_axi_rready} <= 2'b00;
			tick(c);
		end
		// Let one edge pass so the next call never reassigns a handshake line
		@(posedge aclk);
	endtask

	// Wait for a shutdown flag (sel 0) or a window phase (sel 1) of one channel
	task automatic wt(input logic sel, input int ch, input logic [2:0] v);
		n = 0;
		while ((sel ? window_phase[ch*3+:3] : {2'b00, fast_turn_off[ch]}) !== v)
		begin
			@(posedge aclk);
			tick(n);
		end
	endtask

	// Main sequence
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, undervoltage_flag} = '0;
		{charge_pump_failure, pwm_clock_lost, pwm_in} = '0;
		{input_pin_toggle, req, kind, n_fail, tests_run} = '0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("drive_rst", channel_drive_command, 0);
		chk("fto_rst", fast_turn_off, 0);
		foreach (rows[i])
		begin
			xfer(1, rows[i].a, rows[i].d);
			chk("bresp", rsp, rows[i].br);
			xfer(0, rows[i].a, 0);
			chk("rdata", rd, rows[i].q);
			chk("rresp", rsp, rows[i].rr);
		end
		xfer(1, `REG_ONDEMAND, 0);
		xfer(1, `REG_CTRL, 1);
		wt(1, 0, 2);
		xfer(1, `REG_CTRL, 1);
		chk("phase_keep", window_phase[2:0] == 3'h1, 0);
		xfer(1, `REG_CTRL, 0);
		xfer(1, `REG_CTRL, 1);
		wt(1, 0, 1);
		charge_pump_failure <= 1'b1;
		repeat (20) @(posedge aclk);
		chk("cpf_freeze", window_phase[2:0], 1);
		charge_pump_failure <= 1'b0;
		xfer(1, `REG_MODE, 2);
		repeat (20) @(posedge aclk);
		chk("pwm_hold", {window_phase[2:0], channel_drive_command[0]}, 4'h2);
		pwm_in <= 5'h1F;
		wt(1, 0, 4);
		xfer(1, `REG_MODE, 0);
		req <= 5'h01;
		wt(0, 0, 1);
		chk("deglitch", n >= 40 && n <= 50, 1);
		req <= 5'h00;
		chk("drive_off", channel_drive_command[0], 0);
		xfer(0, `REG_QSTATUS, 0);
		chk("qstatus", rd[0], 1);
		xfer(0, `REG_CHSTATUS, 0);
		chk("chstatus", rd[0], 1);
		xfer(1, `REG_CTRL, 1);
		wt(0, 0, 0);
		repeat (3) @(posedge aclk);
		chk("drive_back", channel_drive_command[0], 1);
		undervoltage_flag <= 1'b1;
		wt(0, 0, 1);
		repeat (20) @(posedge aclk);
		chk("uv_hold", fast_turn_off[0], 1);
		undervoltage_flag <= 1'b0;
		xfer(1, `REG_CTRL, 2);
		wt(1, 1, 4);
		req <= 5'h02;
		repeat (20) @(posedge aclk);
		req <= 5'h00;
		repeat (60) @(posedge aclk);
		chk("pulse", fast_turn_off[1], 0);
		xfer(1, `REG_ONDEMAND, 2);
		req <= 5'h02;
		wt(1, 1, 2);
		wt(0, 1, 1);
		req <= 5'h00;
		repeat (2) @(posedge aclk);
		xfer(0, `REG_ONDEMAND, 0);
		chk("ondemand", rd[1], 0);
		xfer(1, `REG_CTRL, 0);
		xfer(1, `REG_MODE, 1);
		input_pin_toggle <= 5'h04;
		wt(1, 2, 4);
		req <= 5'h04;
		wt(0, 2, 1);
		req <= 5'h00;
		wt(0, 2, 0);
		kind <= 3'h5;
		req <= 5'h04;
		wt(0, 2, 1);
		req <= 5'h00;
		repeat (100) @(posedge aclk);
		chk("latch_off", fast_turn_off[2], 1);
		xfer(1, `REG_MODE, 32'h11);
		repeat (5) @(posedge aclk);
		chk("wake_clear", fast_turn_off[2], 0);
		report_and_stop();
	end
endmodule // output_overcurrent_protection_tb
